// ### src/opr_defines.svh
// register offsets, field positions and reset values for the offset/power/event bank
`ifndef OPR_DEFINES_SVH
`define OPR_DEFINES_SVH

// register addresses on the serial register port
`define OPR_ADDR_OFS_HIGH 8'h19
`define OPR_ADDR_PWR_CFG 8'h1a
`define OPR_ADDR_EVT 8'h25

// reset values
`define OPR_RST_OFS_HIGH 8'h00
`define OPR_RST_PWR_CFG 8'h00
`define OPR_RST_EVT 8'h00
`define OPR_RST_RDATA 8'h00

// power profile field
`define OPR_PWR_LC_BIT 0

// event cause field positions in the readable byte
`define OPR_EVT_BOOT_BIT 7
`define OPR_EVT_ANY_BIT 2
`define OPR_EVT_LOW_BIT 1
`define OPR_EVT_HIGH_BIT 0

// index of each sticky flag inside the flag bank
`define OPR_FLG_HIGH 0
`define OPR_FLG_LOW 1
`define OPR_FLG_BOOT 2
`define OPR_FLG_COUNT 3

`endif

// ### src/opr_pkg.sv
// shared types for the offset/power/event register bank
package opr_pkg;
	typedef logic [7:0] opr_byte_t;
	typedef logic signed [15:0] opr_offset_t;
	typedef logic [2:0] opr_flags_t;
endpackage

// ### src/opr_evt_if.sv
// carrier between the register core and the sticky event flag bank
`timescale 1ns/1ps
`default_nettype none
interface opr_evt_if;
	opr_pkg::opr_flags_t set;
	logic clr;
	opr_pkg::opr_flags_t sticky;
	modport core (output set, output clr, input sticky);
	modport flags (input set, input clr, output sticky);
endinterface
`default_nettype wire

// ### src/opr_event_flags.sv
// sticky event flags, cleared by a read of the event cause register
`timescale 1ns/1ps
`default_nettype none
`include "opr_defines.svh"
module opr_event_flags (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_ce,
	opr_evt_if.flags evt
);
	genvar g;
	generate
		for (g = 0; g < `OPR_FLG_COUNT; g = g + 1) begin : gen_flag
			logic flag_r;
			logic flag_nxt;
			// set beats clear so an event landing on the read is kept
			always_comb begin
				flag_nxt = flag_r;
				if (i_ce) begin
					if (evt.set[g]) begin
						flag_nxt = 1'b1;
					end else if (evt.clr) begin
						flag_nxt = 1'b0;
					end
				end
			end
			always_ff @(posedge i_clk_sys or posedge i_rst) begin
				if (i_rst) begin
					flag_r <= 1'b0;
				end else begin
					flag_r <= flag_nxt;
				end
			end
			assign evt.sticky[g] = flag_r;

			a_set_beats_clear: assert property (@(posedge i_clk_sys)
				disable iff (i_rst) i_ce && evt.set[g] |=> flag_r)
				else $error("event lost on concurrent clear");
			a_clear_on_read: assert property (@(posedge i_clk_sys)
				disable iff (i_rst) i_ce && evt.clr && !evt.set[g] |=> !flag_r)
				else $error("flag survived clearing read");
		end
	endgenerate
endmodule
`default_nettype wire

// ### src/opr_regs.sv
// offset, power profile and event cause register bank of the pressure sensor
// Functional notes
// - offset high byte register, read-write
// - high and low bytes form signed offset
// - low-current select bit, zero means low-noise
// - reading event register clears it
// - bit 7 set while boot runs
// - bit 2 set when a low or high event occurred
// - bit 1 set on low event
// - bit 0 set on high event
`timescale 1ns/1ps
`default_nettype none
`include "opr_defines.svh"
module opr_regs (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_offset_low_byte,
	input wire logic i_boot_active,
	input wire logic i_low_event,
	input wire logic i_high_event,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output logic [15:0] o_pressure_offset,
	output logic o_low_current_select
);
	opr_evt_if evt ();

	opr_pkg::opr_byte_t ofs_high_r;
	opr_pkg::opr_byte_t ofs_high_nxt;
	opr_pkg::opr_byte_t pwr_cfg_r;
	opr_pkg::opr_byte_t pwr_cfg_nxt;
	opr_pkg::opr_byte_t rdata_r;
	opr_pkg::opr_byte_t rdata_nxt;
	logic rvalid_r;
	logic rvalid_nxt;
	opr_pkg::opr_offset_t offset_r;
	opr_pkg::opr_offset_t offset_nxt;
	logic lc_r;
	logic lc_nxt;
	opr_pkg::opr_byte_t evt_view;
	logic evt_rd;
	logic any_event;

	// flag bank is kept apart so its set/clear priority stays in one place
	opr_event_flags u_flags (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.evt(evt.flags)
	);

	// event sources and clear strobe toward the flag bank
	assign evt.set[`OPR_FLG_BOOT] = i_boot_active;
	assign evt.set[`OPR_FLG_LOW] = i_low_event;
	assign evt.set[`OPR_FLG_HIGH] = i_high_event;
	assign evt_rd = i_reg_rd && (i_reg_addr == `OPR_ADDR_EVT);
	assign evt.clr = evt_rd;
	assign any_event = evt.sticky[`OPR_FLG_LOW] | evt.sticky[`OPR_FLG_HIGH];

	// readable image of the event cause register
	always_comb begin
		evt_view = 8'h00;
		evt_view[`OPR_EVT_BOOT_BIT] = evt.sticky[`OPR_FLG_BOOT];
		evt_view[`OPR_EVT_ANY_BIT] = any_event;
		evt_view[`OPR_EVT_LOW_BIT] = evt.sticky[`OPR_FLG_LOW];
		evt_view[`OPR_EVT_HIGH_BIT] = evt.sticky[`OPR_FLG_HIGH];
	end

	// register writes; unmapped and read-only addresses ignore writes
	always_comb begin
		ofs_high_nxt = ofs_high_r;
		pwr_cfg_nxt = pwr_cfg_r;
		if (i_ce && i_reg_wr) begin
			case (i_reg_addr)
				`OPR_ADDR_OFS_HIGH: begin
					ofs_high_nxt = i_reg_wdata;
				end
				`OPR_ADDR_PWR_CFG: begin
					// reserved bits stored as written; host keeps them legal
					pwr_cfg_nxt = i_reg_wdata;
				end
				default: begin
					ofs_high_nxt = ofs_high_r;
				end
			endcase
		end
	end

	// read data is captured before the same edge clears the event flags
	always_comb begin
		rdata_nxt = rdata_r;
		rvalid_nxt = rvalid_r;
		if (i_ce) begin
			rvalid_nxt = i_reg_rd;
			if (i_reg_rd) begin
				case (i_reg_addr)
					`OPR_ADDR_OFS_HIGH: begin
						rdata_nxt = ofs_high_r;
					end
					`OPR_ADDR_PWR_CFG: begin
						rdata_nxt = pwr_cfg_r;
					end
					`OPR_ADDR_EVT: begin
						rdata_nxt = evt_view;
					end
					default: begin
						rdata_nxt = `OPR_RST_RDATA;
					end
				endcase
			end
		end
	end

	// outputs follow the stored bytes on the same edge as the write
	always_comb begin
		offset_nxt = {ofs_high_nxt, i_offset_low_byte};
		// mode follows the bit directly; host only flips it in power-down
		lc_nxt = pwr_cfg_nxt[`OPR_PWR_LC_BIT];
		if (!i_ce) begin
			offset_nxt = offset_r;
			lc_nxt = lc_r;
		end
	end

	// state registers
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ofs_high_r <= `OPR_RST_OFS_HIGH;
			pwr_cfg_r <= `OPR_RST_PWR_CFG;
			rdata_r <= `OPR_RST_RDATA;
			rvalid_r <= 1'b0;
			offset_r <= 16'sh0000;
			lc_r <= 1'b0;
		end else begin
			ofs_high_r <= ofs_high_nxt;
			pwr_cfg_r <= pwr_cfg_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			offset_r <= offset_nxt;
			lc_r <= lc_nxt;
		end
	end

	assign o_reg_rdata = rdata_r;
	assign o_reg_rvalid = rvalid_r;
	assign o_pressure_offset = offset_r;
	assign o_low_current_select = lc_r;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	sequence seq_ofs_write;
		i_ce && i_reg_wr && i_reg_addr == `OPR_ADDR_OFS_HIGH;
	endsequence
	sequence seq_evt_read;
		i_ce && i_reg_rd && i_reg_addr == `OPR_ADDR_EVT;
	endsequence
	// no threshold event on the clearing read or after it, so nothing re-sets
	sequence seq_no_event;
		i_ce && !i_low_event && !i_high_event;
	endsequence
	sequence seq_quiet_read;
		seq_evt_read ##0 seq_no_event ##1 seq_no_event ##1 seq_evt_read;
	endsequence

	a_offset_write: assert property (
		seq_ofs_write |=> ofs_high_r == $past(i_reg_wdata))
		else $error("offset high byte not stored");
	a_offset_readback: assert property (
		i_ce && i_reg_rd && i_reg_addr == `OPR_ADDR_OFS_HIGH && !i_reg_wr
		|=> o_reg_rvalid && o_reg_rdata == ofs_high_r)
		else $error("offset high byte readback wrong");
	a_offset_join: assert property (
		i_ce |=> o_pressure_offset == {ofs_high_r, $past(i_offset_low_byte)})
		else $error("signed offset not joined from both bytes");
	a_lc_mode: assert property (
		o_low_current_select == pwr_cfg_r[`OPR_PWR_LC_BIT])
		else $error("low-current mode disagrees with select bit");
	a_read_clears: assert property (
		seq_quiet_read |=> o_reg_rdata[`OPR_EVT_LOW_BIT:`OPR_EVT_HIGH_BIT]
		== 2'h0 && !o_reg_rdata[`OPR_EVT_ANY_BIT])
		else $error("event register not cleared by read");
	a_boot_flag: assert property (
		i_ce && i_boot_active |=> evt.sticky[`OPR_FLG_BOOT])
		else $error("boot flag not set while boot runs");
	a_any_event: assert property (
		seq_evt_read |=> o_reg_rdata[`OPR_EVT_ANY_BIT] ==
		(o_reg_rdata[`OPR_EVT_LOW_BIT] | o_reg_rdata[`OPR_EVT_HIGH_BIT]))
		else $error("any-event bit inconsistent");
	a_low_flag: assert property (
		i_ce && i_low_event ##1 seq_evt_read
		|=> o_reg_rdata[`OPR_EVT_LOW_BIT])
		else $error("low event not reported");
	a_high_flag: assert property (
		i_ce && i_high_event ##1 seq_evt_read
		|=> o_reg_rdata[`OPR_EVT_HIGH_BIT])
		else $error("high event not reported");
	a_reserved_zero: assert property (
		seq_evt_read |=> o_reg_rdata[6:3] == 4'h0)
		else $error("reserved event bits not zero");
	a_ce_freeze: assert property (
		!i_ce |=> $stable(o_reg_rdata) && $stable(o_pressure_offset)
		&& $stable(o_reg_rvalid))
		else $error("state moved with clock enable low");
	// read answer lasts the one cycle after a taken read while i_ce stays high, and holds while i_ce is low
	a_rvalid_pulse: assert property (
		i_ce && !i_reg_rd |=> !o_reg_rvalid)
		else $error("read valid without a taken read");
	// config byte stored whole and bit 0 reaches the mode output at once
	a_pwr_write: assert property (
		i_ce && i_reg_wr && i_reg_addr == `OPR_ADDR_PWR_CFG
		|=> pwr_cfg_r == $past(i_reg_wdata)
		&& o_low_current_select == pwr_cfg_r[`OPR_PWR_LC_BIT])
		else $error("power profile write not applied");
	// holes in the map read as zero rather than a stale byte
	a_unmapped_zero: assert property (
		i_ce && i_reg_rd && i_reg_addr != `OPR_ADDR_OFS_HIGH
		&& i_reg_addr != `OPR_ADDR_PWR_CFG
		&& i_reg_addr != `OPR_ADDR_EVT
		|=> o_reg_rdata == `OPR_RST_RDATA)
		else $error("unmapped read gave nonzero data");
endmodule
`default_nettype wire

// ### tb/opr_host_model.sv
// host model driving the serial register port of the bank
`timescale 1ns/1ps
`default_nettype none
module opr_host_model (
	input wire logic i_clk_sys,
	input wire logic [7:0] i_rdata,
	input wire logic i_rvalid,
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic [7:0] o_wdata,
	output logic o_rd
);
	logic [7:0] cfg_r;
	// idle bus at time zero
	initial begin
		cfg_r = 8'h00;
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// released lines show the inverse so a stale value never passes
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		#1;
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(posedge i_clk_sys);
		#1;
		o_wr = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
	endtask
	// answer is registered on the taking edge and sampled 1 ns after it
	task automatic read(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_clk_sys);
		#1;
		o_addr = a;
		o_rd = 1'b1;
		@(posedge i_clk_sys);
		#1;
		o_rd = 1'b0;
		o_addr = ~a;
		d = {7'h00, i_rvalid, i_rdata};
	endtask
	// only called while no measurement runs; no power-down port here
	task automatic power_cfg(input logic lc);
		cfg_r = {6'h00, cfg_r[1], lc};
		write(8'h1a, cfg_r);
	endtask
endmodule
`default_nettype wire

// ### tb/test_offset_power_event_regs.sv
// self-checking bench for the offset, power profile and event bank
`timescale 1ns/1ps
`default_nettype none
module test_offset_power_event_regs;
	logic clk_sys, rst, ce, wr, rd, boot, lo_ev, hi_ev, lc, rvalid;
	logic [7:0] addr, wdata, rdata, low_b, hi_b;
	logic [15:0] ofs, got;
	int errors, tests_run, i;
	integer seed;
	opr_host_model i_opr_host_model (.i_clk_sys(clk_sys), .i_rdata(rdata),
		.i_rvalid(rvalid), .o_addr(addr), .o_wr(wr), .o_wdata(wdata),
		.o_rd(rd));
	opr_regs i_opr_regs (.i_clk_sys(clk_sys), .i_rst(rst), .i_ce(ce),
		.i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
		.i_reg_rd(rd), .i_offset_low_byte(low_b), .i_boot_active(boot),
		.i_low_event(lo_ev), .i_high_event(hi_ev), .o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid), .o_pressure_offset(ofs),
		.o_low_current_select(lc));
	// expected read answer: valid bit, then boot, zeros, any, low, high
	function automatic logic [15:0] evt_exp(input logic b, input logic l,
		input logic h);
		return {8'h01, b, 4'h0, l | h, l, h};
	endfunction
	task automatic check(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		i_opr_host_model.read(a, got);
		check(got, e);
	endtask
	// one-cycle event pulse, seen by the next event register read taken afterwards
	task automatic pulse(input logic b, input logic l, input logic h);
		boot = b;
		lo_ev = l;
		hi_ev = h;
		@(posedge clk_sys);
		#1;
		boot = 1'b0;
		lo_ev = 1'b0;
		hi_ev = 1'b0;
	endtask
	task automatic end_of_test;
		if (errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// the whole run needs under 120 cycles; this allows 5000
	initial begin
		#100000;
		errors++;
		end_of_test;
	end
	initial begin
		seed = 58;
		errors = 0;
		tests_run = 0;
		rst = 1'b1;
		ce = 1'b1;
		boot = 1'b0;
		lo_ev = 1'b0;
		hi_ev = 1'b0;
		low_b = 8'h00;
		repeat (2) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		// reset values
		check(ofs, 16'h0000);
		check({15'h0000, lc}, 16'h0000);
		rd_chk(8'h19, 16'h0100);
		rd_chk(8'h1a, 16'h0100);
		rd_chk(8'h25, 16'h0100);
		// random offsets with the sign boundary first
		for (i = 0; i < 10; i++) begin
			hi_b = (i == 0) ? 8'h80 : (i == 1) ? 8'hff : 8'($random(seed));
			low_b = 8'($random(seed));
			i_opr_host_model.write(8'h19, hi_b);
			check(ofs, {hi_b, low_b});
			rd_chk(8'h19, {8'h01, hi_b});
		end
		// low-current select set, then back to low-noise
		for (i = 1; i >= 0; i--) begin
			i_opr_host_model.power_cfg(i[0]);
			check({15'h0000, lc}, {15'h0000, i[0]});
			rd_chk(8'h1a, {15'h0080, i[0]});
		end
		// every event mix, then a second read must find it cleared
		for (i = 1; i < 8; i++) begin
			pulse(i[2], i[1], i[0]);
			rd_chk(8'h25, evt_exp(i[2], i[1], i[0]));
			rd_chk(8'h25, 16'h0100);
		end
		// sources still high at the read edge: set wins over the clear
		boot = 1'b1;
		lo_ev = 1'b1;
		hi_ev = 1'b1;
		rd_chk(8'h25, evt_exp(1'b1, 1'b1, 1'b1));
		boot = 1'b0;
		lo_ev = 1'b0;
		hi_ev = 1'b0;
		rd_chk(8'h25, evt_exp(1'b1, 1'b1, 1'b1));
		rd_chk(8'h25, 16'h0100);
		// event register is not writable; unmapped reads give zero
		i_opr_host_model.write(8'h25, 8'hff);
		rd_chk(8'h25, 16'h0100);
		rd_chk(8'h26, 16'h0100);
		// clock enable low: writes, reads and events are all ignored
		@(posedge clk_sys);
		#1;
		ce = 1'b0;
		i_opr_host_model.write(8'h19, ~hi_b);
		check(ofs, {hi_b, low_b});
		rd_chk(8'h19, 16'h0000);
		pulse(1'b0, 1'b1, 1'b0);
		ce = 1'b1;
		rd_chk(8'h19, {8'h01, hi_b});
		rd_chk(8'h25, 16'h0100);
		end_of_test;
	end
endmodule
`default_nettype wire
